// ### logic/sbs_port.sv
// synchronous burst sram port, top level
// Contract
// RULE1: address, data, enables, strobes, advance and writes are captured on the rising edge.
// RULE2: output enable and sleep act at once, without a clock edge.
// RULE3: either address strobe starts a burst.
// RULE4: following burst addresses come from a 2-bit counter loaded at start.
// RULE5: counter steps only when advance is asserted, else holds.
// RULE6: linear-order input picks linear or interleaved burst order.
// RULE7: a fresh address may be given every cycle at full rate.
// RULE8: flow-through select low: read data reach outputs in the access cycle.
// RULE9: flow-through select high: output register adds one cycle of read latency.
// RULE10: single-cycle deselect turns outputs off once the deselect is registered.
// RULE11: dual-cycle deselect turns outputs off after the second rising edge. Code does this only when pipelined; flow-through turns off at the first edge.
// RULE12: byte write stores only selected lanes while byte write enable is asserted.
// RULE13: global write stores every lane regardless of byte controls.
// RULE14: unset modes default to single-cycle deselect, interleaved, pipelined.
// RULE15: writes are timed internally from the registered command.
// RULE16: two low address inputs are low bits and preset the counter.
// RULE17: selected only while first and third enables low, second high.
// RULE18: sleep input high puts the device in power-down.
// RULE19: advance input is active low.
// RULE20: interleaved is start xor step; linear is start plus step modulo four.
// RULE21: data driven only when selected, output enable low, no write.
`timescale 1ns/100ps
`default_nettype none
module sbs_port
  import sbs_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // address
  input  wire sbs_hi_t    addr_hi,
  input  wire sbs_lsbs_t  burst_start_lsbs,
  // data pins
  input  wire sbs_data_t  dq_in,
  output var  sbs_data_t  dq_out,
  output var  logic       dq_oe,
  // chip enables
  input  wire logic       chip_select_first_n,
  input  wire logic       chip_select_second,
  input  wire logic       chip_select_third_n,
  // burst control
  input  wire logic       processor_addr_strobe_n,
  input  wire logic       controller_addr_strobe_n,
  input  wire logic       burst_advance_n,
  // write control
  input  wire logic       byte_write_enable_n,
  input  wire sbs_lanes_t byte_lane_write_n,
  input  wire logic       global_write_n,
  // asynchronous controls
  input  wire logic       output_enable_n,
  input  wire logic       sleep_request,
  // mode straps
  input  wire logic       flow_through_select_n,
  input  wire logic       linear_order_select_n,
  input  wire logic       deselect_mode_select
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic       pipe_mode_reg;
  logic       lin_n_reg;
  logic       scd_reg;
  logic       chip_sel;
  logic       strobe;
  logic       start;
  logic       deselect_now;
  logic       cont;
  logic       access;
  sbs_lanes_t lane_we;
  logic       write_now;
  logic       read_go;
  logic       active_reg;
  sbs_hi_t    hi_reg;
  sbs_addr_t  mem_addr;
  sbs_data_t  mem_rdata;
  sbs_data_t  pipe_reg;
  logic       rd1_reg;
  logic       oe_reg;
  logic       oe_next;

  sbs_burst_if bif ();

  ////////////////////////////////////////////////////////////////////////////
  // mode straps

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pipe_mode_reg <= FT_PIPE_DEFAULT;  // RULE14
      lin_n_reg     <= LIN_N_DEFAULT;    // RULE14
      scd_reg       <= SCD_MODE_DEFAULT; // RULE14
    end else begin
      pipe_mode_reg <= flow_through_select_n;
      lin_n_reg     <= linear_order_select_n;
      scd_reg       <= deselect_mode_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  always_comb begin
    chip_sel     = !chip_select_first_n && chip_select_second && !chip_select_third_n; // RULE17
    strobe       = !processor_addr_strobe_n || !controller_addr_strobe_n;             // RULE3
    start        = strobe && chip_sel && !sleep_request;                               // RULE3
    deselect_now = strobe && !chip_sel && !sleep_request;
    cont         = !strobe && active_reg && !sleep_request;                            // RULE18
    access       = start || cont;
  end

  // write lane decode
  always_comb begin
    if (!access) begin
      lane_we = LANES_NONE;
    end else if (!global_write_n) begin
      lane_we = LANES_ALL;            // RULE13
    end else if (!byte_write_enable_n) begin
      lane_we = ~byte_lane_write_n;   // RULE12
    end else begin
      lane_we = LANES_NONE;
    end
    write_now = |lane_we;
    read_go   = access && !write_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst state

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      active_reg <= 1'b0;
    end else if (start) begin
      active_reg <= 1'b1;
    end else if (deselect_now) begin
      active_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hi_reg <= '0;
    end else if (start) begin
      hi_reg <= addr_hi; // RULE7
    end
  end

  always_comb begin
    bif.load       = start;                        // RULE16
    bif.start_lsbs = burst_start_lsbs;             // RULE16
    bif.advance    = cont && !burst_advance_n;     // RULE5 RULE19
    bif.linear     = !lin_n_reg;                   // RULE6
    mem_addr       = {start ? addr_hi : hi_reg, bif.cur_lsbs}; // RULE4
  end

  sbs_burst_counter i_sbs_burst_counter (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .bif     (bif.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // array, writes timed by the clock edge

  sbs_mem i_sbs_mem (
    .sys_clk (sys_clk),
    .addr    (mem_addr),
    .lane_we (lane_we),  // RULE15
    .wdata   (dq_in),    // RULE1
    .rdata   (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read pipeline and output enable

  always_ff @(posedge sys_clk) begin
    pipe_reg <= mem_rdata; // RULE9
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd1_reg <= 1'b0;
    end else begin
      rd1_reg <= read_go;
    end
  end

  always_comb begin
    if (!pipe_mode_reg) begin
      oe_next = read_go;                                  // RULE8
    end else if (write_now) begin
      oe_next = 1'b0;                                     // RULE21
    end else if (scd_reg && deselect_now) begin
      oe_next = 1'b0;                                     // RULE10
    end else begin
      oe_next = rd1_reg;                                  // RULE9 RULE11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // output mux and asynchronous gating
  always_comb begin
    dq_out = pipe_mode_reg ? pipe_reg : mem_rdata;           // RULE8 RULE9
    dq_oe  = oe_reg && !output_enable_n && !sleep_request;   // RULE2 RULE21
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_hold_no_adv;
    (cont && burst_advance_n) |-> (bif.cur_lsbs == $past(bif.cur_lsbs));
  endproperty
  a_hold_no_adv: assert property (p_hold_no_adv) else $error("burst address moved without advance"); // RULE5

  property p_preset;
    (start && !write_now) ##1 (cont && burst_advance_n) |-> (mem_addr[1:0] == $past(burst_start_lsbs));
  endproperty
  a_preset: assert property (p_preset) else $error("counter not preset from low address bits"); // RULE16

  property p_interleave;
    (start && lin_n_reg) ##1 (cont && !burst_advance_n && lin_n_reg)
      |-> (mem_addr[1:0] == ($past(burst_start_lsbs) ^ STEP_ONE));
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleaved step wrong"); // RULE20

  property p_linear;
    (start && !lin_n_reg) ##1 (cont && !burst_advance_n && !lin_n_reg)
      |-> (mem_addr[1:0] == sbs_lsbs_t'($past(burst_start_lsbs) + STEP_ONE));
  endproperty
  a_linear: assert property (p_linear) else $error("linear step wrong"); // RULE20

  property p_flow_latency;
    (read_go && !pipe_mode_reg && !flow_through_select_n) |=> oe_reg;
  endproperty
  a_flow_latency: assert property (p_flow_latency) else $error("flow-through read not driven next cycle"); // RULE8

  property p_pipe_latency;
    (read_go && pipe_mode_reg && flow_through_select_n && !rd1_reg)
      ##1 (!write_now && !deselect_now && pipe_mode_reg) |-> !oe_reg ##1 oe_reg;
  endproperty
  a_pipe_latency: assert property (p_pipe_latency) else $error("pipelined read latency wrong"); // RULE9

  property p_scd_off;
    (pipe_mode_reg && scd_reg && deselect_now) |=> !oe_reg;
  endproperty
  a_scd_off: assert property (p_scd_off) else $error("single-cycle deselect left outputs on"); // RULE10

  property p_dcd_off;
    (pipe_mode_reg && flow_through_select_n && !scd_reg && !deselect_mode_select
      && deselect_now && rd1_reg) |=> oe_reg ##1 !oe_reg;
  endproperty
  a_dcd_off: assert property (p_dcd_off) else $error("dual-cycle deselect timing wrong"); // RULE11

  property p_global_write;
    (access && !global_write_n) |-> (lane_we == LANES_ALL);
  endproperty
  a_global_write: assert property (p_global_write) else $error("global write missed a lane"); // RULE13

  property p_byte_gate;
    (global_write_n && byte_write_enable_n) |-> (lane_we == LANES_NONE);
  endproperty
  a_byte_gate: assert property (p_byte_gate) else $error("lane written without byte enable"); // RULE12

  property p_no_drive_after_write;
    write_now |=> !dq_oe;
  endproperty
  a_no_drive_after_write: assert property (p_no_drive_after_write) else $error("outputs driven after write"); // RULE21

  property p_unselected;
    (!chip_sel || sleep_request) && !active_reg |-> (lane_we == LANES_NONE);
  endproperty
  a_unselected: assert property (p_unselected) else $error("write while not selected"); // RULE17

  property p_mode_defaults;
    $rose(nrst) |-> (pipe_mode_reg == FT_PIPE_DEFAULT) && (lin_n_reg == LIN_N_DEFAULT)
      && (scd_reg == SCD_MODE_DEFAULT);
  endproperty
  a_mode_defaults: assert property (p_mode_defaults) else $error("mode defaults not loaded"); // RULE14

  property p_oe_async;
    (output_enable_n || sleep_request) |-> !dq_oe;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("outputs driven while disabled"); // RULE2

  property p_sleep_idle;
    sleep_request |-> !access ##1 (active_reg == $past(active_reg));
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("command taken during sleep"); // RULE18

  property p_strobe_start;
    (processor_addr_strobe_n != controller_addr_strobe_n) && chip_sel && !sleep_request |=> active_reg;
  endproperty
  a_strobe_start: assert property (p_strobe_start) else $error("single strobe did not start a burst"); // RULE3

  property p_start_addr;
    start |-> (mem_addr == {addr_hi, burst_start_lsbs});
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("fresh address not used at start"); // RULE7

  property p_adv_steps;
    (cont && !burst_advance_n) |-> (bif.cur_lsbs != $past(bif.cur_lsbs));
  endproperty
  a_adv_steps: assert property (p_adv_steps) else $error("low advance did not step the counter"); // RULE19

  property p_wrap4;
    start ##1 (cont && !burst_advance_n) [*4] |-> (mem_addr[1:0] == $past(burst_start_lsbs, 4));
  endproperty
  a_wrap4: assert property (p_wrap4) else $error("counter did not wrap after four steps"); // RULE4

  property p_deselect_ends;
    deselect_now |=> !active_reg;
  endproperty
  a_deselect_ends: assert property (p_deselect_ends) else $error("deselect left burst active"); // RULE17

  property p_byte_lanes;
    (access && global_write_n && !byte_write_enable_n) |-> (lane_we == ~byte_lane_write_n);
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes not as selected"); // RULE12

  c_burst4: cover property (start ##1 (cont && !burst_advance_n) [*3]);
  c_back_to_back: cover property (start ##1 start ##1 start);
  c_dcd_deselect: cover property (!scd_reg && rd1_reg && deselect_now);
  c_sleep_in_burst: cover property (active_reg && sleep_request);
  c_read_then_write: cover property (read_go ##1 write_now);

endmodule : sbs_port
`default_nettype wire

// ### logic/sbs_pkg.sv
// constants and types for the synchronous burst sram port
package sbs_pkg;

  // widths
  localparam int ADDR_W  = 20;
  localparam int HI_W    = ADDR_W - 2;
  localparam int LANES   = 4;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int BURST_W = 2;

  // mode strap reset values
  localparam logic FT_PIPE_DEFAULT   = 1'b1;
  localparam logic LIN_N_DEFAULT     = 1'b1;
  localparam logic SCD_MODE_DEFAULT  = 1'b1;

  // burst step constants
  localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] STEP_ONE  = 2'h1;

  // lane masks
  localparam logic [LANES-1:0] LANES_ALL  = 4'hf;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;

  typedef logic [BURST_W-1:0] sbs_lsbs_t;
  typedef logic [HI_W-1:0]    sbs_hi_t;
  typedef logic [ADDR_W-1:0]  sbs_addr_t;
  typedef logic [DATA_W-1:0]  sbs_data_t;
  typedef logic [LANES-1:0]   sbs_lanes_t;

endpackage : sbs_pkg

// ### logic/sbs_burst_if.sv
// link between access control and burst counter
`timescale 1ns/100ps
`default_nettype none
interface sbs_burst_if;
  import sbs_pkg::*;
  logic      load;
  logic      advance;
  logic      linear;
  sbs_lsbs_t start_lsbs;
  sbs_lsbs_t cur_lsbs;

  modport ctl (output load, output advance, output linear, output start_lsbs, input cur_lsbs);
  modport cnt (input load, input advance, input linear, input start_lsbs, output cur_lsbs);
endinterface : sbs_burst_if
`default_nettype wire

// ### logic/sbs_burst_counter.sv
// two bit burst counter with linear and interleaved order
`timescale 1ns/100ps
`default_nettype none
module sbs_burst_counter
  import sbs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // control side
  sbs_burst_if.cnt bif
);

  sbs_lsbs_t base_reg;
  sbs_lsbs_t step_reg;
  sbs_lsbs_t step_next;

  always_comb begin
    step_next = bif.advance ? step_reg + STEP_ONE : step_reg; // RULE5
  end

  // address low bits for this cycle
  always_comb begin
    if (bif.load) begin
      bif.cur_lsbs = bif.start_lsbs;
    end else if (bif.linear) begin
      bif.cur_lsbs = base_reg + step_next; // RULE20
    end else begin
      bif.cur_lsbs = base_reg ^ step_next; // RULE20
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      base_reg <= STEP_ZERO;
    end else if (bif.load) begin
      base_reg <= bif.start_lsbs; // RULE4
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      step_reg <= STEP_ZERO;
    end else if (bif.load) begin
      step_reg <= STEP_ZERO;
    end else begin
      step_reg <= step_next;
    end
  end

endmodule : sbs_burst_counter
`default_nettype wire

// ### logic/sbs_mem.sv
// byte lane writable array with registered read data
`timescale 1ns/100ps
`default_nettype none
module sbs_mem
  import sbs_pkg::*;
(
  // clock
  input wire logic       sys_clk,
  // access
  input wire sbs_addr_t  addr,
  input wire sbs_lanes_t lane_we,
  input wire sbs_data_t  wdata,
  output var sbs_data_t  rdata
);

  sbs_data_t mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_we[i]) begin
        mem[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    rdata <= mem[addr];
  end

endmodule : sbs_mem
`default_nettype wire

// ### testbench/sbs_host_model.sv
// host side pin driver model for the burst sram port
`timescale 1ns/100ps
`default_nettype none
module sbs_host_model
  import sbs_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // pin bus
  output var  sbs_addr_t  addr,
  output var  sbs_data_t  dq,
  output var  logic [2:0] cs,
  output var  logic [1:0] stb_n,
  output var  logic [6:0] ctl
);
  logic [1:0] rot = 2'h0;
  initial begin
    addr = 20'h0;
    dq = 36'h0;
    cs = 3'h2;
    stb_n = 2'h3;
    ctl = 7'h7f;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one bus cycle; ctl is advance, global write, byte enable, lanes
  task automatic cyc(input logic [1:0] s, input logic sel, input sbs_addr_t a,
                     input logic [6:0] c, input sbs_data_t d);
    @(posedge sys_clk);
    stb_n <= s;
    cs <= sel ? 3'h2 : (rot[0] ? 3'h6 : (rot[1] ? 3'h0 : 3'h3));
    rot <= rot + 2'h1;
    addr <= a;
    ctl <= c;
    dq <= (!c[5] || !c[4]) ? d : ~dq;
  endtask : cyc
endmodule : sbs_host_model
`default_nettype wire

// ### testbench/sbs_port_bench.sv
// self-checking bench for the burst sram port
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module sbs_port_bench
  import sbs_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       oe_n = 1'b0;
  logic       sleep = 1'b0;
  logic [2:0] modes = 3'h7;
  logic       chk_en = 1'b0;
  sbs_addr_t  addr;
  sbs_data_t  dq;
  sbs_data_t  dq_out;
  logic       dq_oe;
  logic [2:0] cs;
  logic [1:0] stb_n;
  logic [6:0] ctl;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         seed = 32'hb1db3a6b;
  // reference state
  sbs_data_t  mem [16];
  sbs_data_t  e_dat;
  sbs_data_t  dat1;
  logic       act = 1'b0;
  logic       rd1 = 1'b0;
  logic       e_oe = 1'b0;
  logic [2:0] md = 3'h7;
  sbs_hi_t    hi;
  sbs_lsbs_t  st;
  sbs_lsbs_t  step;

  sbs_port i_sbs_port (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .addr_hi(addr[ADDR_W-1:2]),
    .burst_start_lsbs(addr[1:0]),
    .dq_in(dq),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .chip_select_first_n(cs[2]),
    .chip_select_second(cs[1]),
    .chip_select_third_n(cs[0]),
    .processor_addr_strobe_n(stb_n[1]),
    .controller_addr_strobe_n(stb_n[0]),
    .burst_advance_n(ctl[6]),
    .byte_write_enable_n(ctl[4]),
    .byte_lane_write_n(ctl[3:0]),
    .global_write_n(ctl[5]),
    .output_enable_n(oe_n),
    .sleep_request(sleep),
    .flow_through_select_n(modes[2]),
    .linear_order_select_n(modes[1]),
    .deselect_mode_select(modes[0])
  );
  sbs_host_model i_sbs_host_model (
    .sys_clk(sys_clk),
    .addr(addr),
    .dq(dq),
    .cs(cs),
    .stb_n(stb_n),
    .ctl(ctl)
  );

  initial forever #50 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  // reference model
  function automatic sbs_lsbs_t next_lsbs(input sbs_lsbs_t s, input sbs_lsbs_t n, input logic il);
    return il ? s ^ n : s + n;
  endfunction : next_lsbs

  always @(posedge sys_clk) begin : ref_model
    logic       s;
    logic       dsl;
    logic       acc;
    logic [3:0] idx;
    sbs_lanes_t ln;
    sbs_data_t  rdat;
    s = !stb_n[0] || !stb_n[1];
    dsl = 1'b0;
    acc = 1'b0;
    ln = 4'h0;
    if (!nrst) begin
      act = 1'b0;
      rd1 = 1'b0;
      e_oe = 1'b0;
      md = 3'h7;
    end else begin
      if (!sleep) begin
        dsl = s && cs !== 3'h2;
        acc = s ? cs === 3'h2 : act;
        if (s) begin
          act = cs === 3'h2;
          hi = addr[ADDR_W-1:2];
          st = addr[1:0];
          step = 2'h0;
        end else if (act && !ctl[6]) begin
          step = step + 2'h1;
        end
        if (acc) ln = !ctl[5] ? 4'hf : (!ctl[4] ? ~ctl[3:0] : 4'h0);
      end
      idx = {hi[1:0], next_lsbs(st, step, md[1])};
      rdat = mem[idx];
      for (int i = 0; i < LANES; i++)
        if (ln[i]) mem[idx][i*LANE_W +: LANE_W] = dq[i*LANE_W +: LANE_W];
      if (!md[2]) begin
        e_oe = acc && ln == 4'h0;
        e_dat = rdat;
      end else begin
        e_oe = rd1 && ln == 4'h0 && !(md[0] && dsl);
        e_dat = dat1;
      end
      rd1 = acc && ln == 4'h0;
      dat1 = rdat;
      md = modes;
    end
  end

  always @(negedge sys_clk) begin
    if (chk_en) begin
      `CHK(dq_oe, e_oe && !oe_n && !sleep)
      if (e_oe) `CHK(dq_out, e_dat)
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // stimulus
  task automatic sweep(input bit wr);
    logic [31:0] r;
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      i_sbs_host_model.cyc({r[1], ~r[1]}, 1'b1, ADDR_W'(k), wr ? 7'h5f : 7'h7f, {r, r[3:0]});
    end
    i_sbs_host_model.cyc(2'h2, 1'b0, 20'h0, 7'h7f, 36'h0);
  endtask : sweep

  task automatic burst();
    logic [31:0] r;
    logic [31:0] s;
    s = $random(seed);
    for (int k = 0; k <= int'(s[7:5]); k++) begin
      r = $random(seed);
      i_sbs_host_model.cyc(k == 0 ? {r[1], ~r[1]} : 2'h3, 1'b1, k == 0 ? ADDR_W'(s[3:0]) : r[19:0],
        s[4] ? {r[6], r[0], r[13], r[5:2]} : {r[6], 2'h3, r[5:2]}, {r, r[3:0]});
      oe_n <= !s[4] && r[7] && r[8];
      sleep <= !s[4] && r[9] && r[10] && r[11];
    end
    i_sbs_host_model.cyc({s[8], ~s[8]}, 1'b0, 20'h0, 7'h7f, 36'h0);
    oe_n <= 1'b0;
    sleep <= 1'b0;
  endtask : burst

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    @(posedge sys_clk);
    chk_en <= 1'b1;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    sweep(1'b1);
    for (int m = 7; m >= 0; m--) begin
      modes <= 3'(m);
      if (m == 3) begin
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
      end
      repeat (2) i_sbs_host_model.cyc(2'h3, 1'b1, 20'h0, 7'h7f, 36'h0);
      sweep(1'b0);
      repeat (10) burst();
    end
    print_verdict();
  end
endmodule : sbs_port_bench
`default_nettype wire
